/* driver_fault_supervisor.v */
// Purpose: Fault supervision for four low-side channels and a pump pre-driver
// Assumes: Comparator inputs asynchronous; host strobes on core_clk
// Notes: Regulation loop and SPI framing live elsewhere
`timescale 1ns/1ps
`include "supervisor_defines.vh"
module driver_fault_supervisor #(
    parameter CH = `CHANNELS,
    parameter TW = `TARGET_WIDTH
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Low-side comparators, one bit per channel, asynchronous
    input wire [CH-1:0] openLoadBelow,
    input wire [CH-1:0] drainAboveRef,
    input wire [CH-1:0] chanOverCurrent,
    input wire [CH-1:0] chanOverTemp,
    // Host command strobes, one cycle
    input wire [CH-1:0] targetWrite,
    input wire [TW-1:0] targetValue,
    input wire [CH-1:0] channelFaultClear,
    input wire [CH-1:0] regErrRead,
    // Regulation measurement, one packed word per channel
    input wire [CH-1:0] regulationMode,
    input wire [CH*TW-1:0] adcCurrent,
    // Pump
    input wire pumpDriveInput,
    input wire pumpOverCurrent,
    input wire pumpOverTemp,
    input wire pumpFaultClear,
    // Channel outputs
    output reg [CH-1:0] channelOn,
    output reg [CH*TW-1:0] targetCode,
    output reg [CH-1:0] openLoadFlag,
    output reg [CH-1:0] drainLevelFlag,
    output reg [CH-1:0] overCurrentFlag,
    output reg [CH-1:0] overTempFlag,
    output reg [CH-1:0] regulationErrorFlag,
    // Pump outputs
    output reg pumpGateOutput,
    output reg pumpOcFlag,
    output reg pumpOtFlag
);
    // ==========================================
    // Input synchronisers
    reg [CH-1:0] olMeta, olSync, dsMeta, dsSync, ocMeta, ocSync, otMeta, otSync;
    reg [2:0] pMeta, pSync;

    // Every comparator and pump level passes two flip-flops
    always @(posedge core_clk) begin
        if (sys_rst) begin
            olMeta <= {CH{1'b0}};
            olSync <= {CH{1'b0}};
            dsMeta <= {CH{1'b0}};
            dsSync <= {CH{1'b0}};
            ocMeta <= {CH{1'b0}};
            ocSync <= {CH{1'b0}};
            otMeta <= {CH{1'b0}};
            otSync <= {CH{1'b0}};
            pMeta <= 3'h0;
            pSync <= 3'h0;
        end else begin
            olMeta <= openLoadBelow;
            olSync <= olMeta;
            dsMeta <= drainAboveRef;
            dsSync <= dsMeta;
            ocMeta <= chanOverCurrent;
            ocSync <= ocMeta;
            otMeta <= chanOverTemp;
            otSync <= otMeta;
            pMeta <= {pumpDriveInput, pumpOverCurrent, pumpOverTemp};
            pSync <= pMeta;
        end
    end

    wire pDrive = pSync[2];
    wire pOc = pSync[1];
    wire pOt = pSync[0];

    // ==========================================
    // Per-channel supervision
    wire [CH-1:0] olQual, dsQual, ocQual, otQual;

    genvar i;
    generate
        for (i = 0; i < CH; i = i + 1) begin : chan
            wire [TW-1:0] tgt = targetCode[i*TW +: TW];
            wire [TW-1:0] adc = adcCurrent[i*TW +: TW];
            wire [TW-1:0] diff = (tgt > adc) ? (tgt - adc) : (adc - tgt);
            // Off means zero code or a fault shutdown
            wire isOn = channelOn[i];
            wire overErr = regulationMode[i] && isOn && (diff >= `REG_ERR_THRESHOLD);

            // Open load only looked at while the channel is off
            persist_filter u_ol (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .condIn(olSync[i] & ~isOn),
                .qualified(olQual[i])
            );
            persist_filter u_ds (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .condIn(dsSync[i]),
                .qualified(dsQual[i])
            );
            persist_filter u_oc (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .condIn(ocSync[i]),
                .qualified(ocQual[i])
            );
            persist_filter u_ot (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .condIn(otSync[i]),
                .qualified(otQual[i])
            );

            // Flags, shutdown and stored command
            always @(posedge core_clk) begin
                if (sys_rst) begin
                    openLoadFlag[i] <= 1'b0;
                    drainLevelFlag[i] <= 1'b0;
                    overCurrentFlag[i] <= 1'b0;
                    overTempFlag[i] <= 1'b0;
                    regulationErrorFlag[i] <= 1'b0;
                    channelOn[i] <= 1'b0;
                    targetCode[i*TW +: TW] <= `TARGET_OFF;
                end else begin
                    // Open load is report-only; set beats clear
                    if (olQual[i]) begin
                        openLoadFlag[i] <= 1'b1;
                    end else if (channelFaultClear[i]) begin
                        openLoadFlag[i] <= 1'b0;
                    end
                    // Drain level is a filtered real-time state
                    drainLevelFlag[i] <= dsQual[i];
                    // Overcurrent: clear ignored while still qualified
                    if (ocQual[i]) begin
                        overCurrentFlag[i] <= 1'b1;
                    end else if (channelFaultClear[i]) begin
                        overCurrentFlag[i] <= 1'b0;
                    end
                    // Overtemperature clear waits for normal temperature
                    if (otQual[i] || otSync[i]) begin
                        overTempFlag[i] <= otQual[i] | overTempFlag[i];
                    end else if (channelFaultClear[i]) begin
                        overTempFlag[i] <= 1'b0;
                    end
                    // Regulation error latched, read clears, set wins
                    if (overErr) begin
                        regulationErrorFlag[i] <= 1'b1;
                    end else if (regErrRead[i]) begin
                        regulationErrorFlag[i] <= 1'b0;
                    end
                    // Command store and driver enable
                    if (otQual[i]) begin
                        targetCode[i*TW +: TW] <= `TARGET_OFF;
                        channelOn[i] <= 1'b0;
                    end else if (ocQual[i]) begin
                        channelOn[i] <= 1'b0;
                    end else if (targetWrite[i]) begin
                        targetCode[i*TW +: TW] <= targetValue;
                        // Resume only once overcurrent and overtemperature flags are cleared
                        channelOn[i] <= (targetValue != `TARGET_OFF) &&
                            !overCurrentFlag[i] && !overTempFlag[i];
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // Pump supervision
    wire pumpOcQual, pumpOtQual;
    reg pumpArmed_reg;

    // A clear with pumpOcFlag set empties the accumulator, else a full count fires at once after restart
    pump_oc_accum u_pump_oc (
        .core_clk(core_clk),
        .sys_rst(sys_rst | (pumpFaultClear & pumpOcFlag)),
        .driveOn(pDrive & pumpArmed_reg),
        .overCurrent(pOc),
        .ocFault(pumpOcQual)
    );

    persist_filter u_pump_ot (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .condIn(pOt),
        .qualified(pumpOtQual)
    );

    // Pump flags and gate; after a fault the drive must go low then high
    always @(posedge core_clk) begin
        if (sys_rst) begin
            pumpOcFlag <= 1'b0;
            pumpOtFlag <= 1'b0;
            pumpArmed_reg <= 1'b0;
            pumpGateOutput <= 1'b0;
        end else begin
            if (pumpOcQual) begin
                pumpOcFlag <= 1'b1;
            end else if (pumpFaultClear) begin
                pumpOcFlag <= 1'b0;
            end
            if (pumpOtQual) begin
                pumpOtFlag <= 1'b1;
            end else if (pumpFaultClear) begin
                pumpOtFlag <= 1'b0;
            end
            // Re-arm only with flags clear and drive low, so reassertion restarts
            if (pumpOcQual || pumpOtQual) begin
                pumpArmed_reg <= 1'b0;
            end else if (!pDrive && !pumpOcFlag && !pumpOtFlag) begin
                pumpArmed_reg <= 1'b1;
            end
            pumpGateOutput <= pDrive && pumpArmed_reg && !pumpOcQual && !pumpOtQual;
        end
    end
endmodule

/* supervisor_defines.vh */
// Purpose: Shared constants for the driver fault supervisor
// Assumes: core_clk at 100 MHz
// Notes: Times in ns, cycle counts derived from the clock period
//
// How it works
// - Low open-load qualified sets channel open-load flag
// - Open-load evaluated only while channel off
// - Drain above reference for qualify time sets flag
// - Qualified overcurrent switches channel off, sets flag
// - Overtemperature: off, flag, stored command cleared
// - Overtemperature clear only once temperature normal
// - Regulation error threshold 25 LSB, regulation only
// - Pump overcurrent checked only while pump on
// - Pump accumulation enabled after half qualify time
// - Accumulated overcurrent beyond qualify time faults pump
// - Drive input low holds accumulation counter
// - Drive on without overcurrent after masking resets counter
// - Pump overtemperature: off, flag, clear and reassert
// - Regulation error flag latched, cleared by read
// - Target is 10-bit code, zero means off
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH

// ==========================================
// Timing
// Terms kept 16 bits wide so the derived counts fit the counters exactly
`define CLK_PERIOD_NS 16'h000a
`define QUALIFY_TIME_NS 16'h03e8
`define QUALIFY_CYCLES ((`QUALIFY_TIME_NS + `CLK_PERIOD_NS - 16'h0001) / `CLK_PERIOD_NS)
`define MASK_CYCLES ((`QUALIFY_TIME_NS / 16'h0002 + `CLK_PERIOD_NS - 16'h0001) / `CLK_PERIOD_NS)
`define CNT_WIDTH 16

// ==========================================
// Channel and regulation
`define CHANNELS 4
`define TARGET_WIDTH 10
`define TARGET_OFF 10'h000
`define REG_ERR_THRESHOLD 10'h019

`endif

/* persist_filter.v */
// Purpose: Qualifies a condition that persists for a number of cycles
// Assumes: Condition input already synchronised
// Notes: Restarts on any drop before qualification
`timescale 1ns/1ps
`include "supervisor_defines.vh"
module persist_filter #(
    parameter [`CNT_WIDTH-1:0] LIMIT = `QUALIFY_CYCLES
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Condition
    input wire condIn,
    output reg qualified
);
    reg [`CNT_WIDTH-1:0] count_reg;

    // ==========================================
    // Count while present, restart on drop
    always @(posedge core_clk) begin
        if (sys_rst || !condIn) begin
            count_reg <= {`CNT_WIDTH{1'b0}};
            qualified <= 1'b0;
        end else if (count_reg >= LIMIT - 16'h0001) begin
            qualified <= 1'b1;
        end else begin
            count_reg <= count_reg + 16'h0001;
        end
    end
endmodule

/* pump_oc_accum.v */
// Purpose: Masked, cumulative pump overcurrent qualification
// Assumes: Inputs synchronised to core_clk
// Notes: Counter holds while drive is low, so short bursts add up
`timescale 1ns/1ps
`include "supervisor_defines.vh"
module pump_oc_accum #(
    parameter [`CNT_WIDTH-1:0] MASK = `MASK_CYCLES,
    parameter [`CNT_WIDTH-1:0] LIMIT = `QUALIFY_CYCLES
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Conditions
    input wire driveOn,
    input wire overCurrent,
    output reg ocFault
);
    reg [`CNT_WIDTH-1:0] mask_reg;
    reg [`CNT_WIDTH-1:0] accum_reg;
    wire maskDone;

    assign maskDone = (mask_reg >= MASK);

    // ==========================================
    // Masking timer restarts each time drive goes low
    always @(posedge core_clk) begin
        if (sys_rst || !driveOn) begin
            mask_reg <= {`CNT_WIDTH{1'b0}};
        end else if (!maskDone) begin
            mask_reg <= mask_reg + 16'h0001;
        end
    end

    // ==========================================
    // Accumulate, hold or reset
    always @(posedge core_clk) begin
        if (sys_rst) begin
            accum_reg <= {`CNT_WIDTH{1'b0}};
            ocFault <= 1'b0;
        end else if (!driveOn) begin
            accum_reg <= accum_reg;
            ocFault <= 1'b0;
        end else if (!maskDone) begin
            ocFault <= 1'b0;
        end else if (overCurrent) begin
            ocFault <= (accum_reg >= LIMIT);
            if (accum_reg <= LIMIT) begin
                accum_reg <= accum_reg + 16'h0001;
            end
        end else begin
            accum_reg <= {`CNT_WIDTH{1'b0}};
            ocFault <= 1'b0;
        end
    end
endmodule

/* supervisor_props.sv */
// Purpose: Port-level assertions for the driver fault supervisor
// Assumes: Single core_clk domain, sync active-high sys_rst
// Notes: Each rule is watched on the channel the directed tests exercise
`timescale 1ns/1ps
module supervisor_props (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Inputs watched
    input wire [3:0] chanOverCurrent,
    input wire [3:0] chanOverTemp,
    input wire [3:0] targetWrite,
    input wire [9:0] targetValue,
    input wire [3:0] channelFaultClear,
    input wire [3:0] regErrRead,
    // Outputs watched
    input wire [3:0] channelOn,
    input wire [39:0] targetCode,
    input wire [3:0] openLoadFlag,
    input wire [3:0] overCurrentFlag,
    input wire [3:0] overTempFlag,
    input wire [3:0] regulationErrorFlag,
    input wire pumpGateOutput,
    input wire pumpOcFlag,
    input wire pumpOtFlag
);
    // ==========================================
    // Channel rules
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_oc_forces_off: assert property (overCurrentFlag[0] && $past(overCurrentFlag[0])
        |-> !channelOn[0]) else $error("channel on with overcurrent flag");
    chk_oc_needs_persist: assert property ($rose(overCurrentFlag[0])
        |-> $past(chanOverCurrent[0], 5) && $past(chanOverCurrent[0], 90))
        else $error("overcurrent flag without persistent condition");
    chk_ot_drops_cmd: assert property ($rose(overTempFlag[1])
        |-> ##[0:1] targetCode[19:10] == 10'h000) else $error("stored command kept");
    chk_ot_clear_held: assert property (chanOverTemp[1][*4] ##0 overTempFlag[1]
        |=> overTempFlag[1]) else $error("overtemp cleared while hot");
    chk_ol_off_only: assert property ($rose(openLoadFlag[2])
        |-> !$past(channelOn[2], 5)) else $error("open load flagged while on");
    // Refusal cases are kept out of the antecedent
    chk_target_store: assert property (targetWrite[0] && !overCurrentFlag[0]
        && !overTempFlag[0] && !(chanOverCurrent[0] | chanOverTemp[0])
        && !($past(chanOverCurrent[0], 3) | $past(chanOverTemp[0], 3))
        |=> targetCode[9:0] == $past(targetValue) && channelOn[0] == |$past(targetValue))
        else $error("target write not applied");
    chk_clear_oc_flag: assert property (channelFaultClear[0] && !chanOverCurrent[0]
        && !$past(chanOverCurrent[0], 3) |=> !overCurrentFlag[0])
        else $error("overcurrent flag not cleared");
    chk_err_latched: assert property (regulationErrorFlag[0] && !regErrRead[0]
        |=> regulationErrorFlag[0]) else $error("regulation error flag lost");
    // ==========================================
    // Pump rules
    chk_pump_oc_gate: assert property (pumpOcFlag && $past(pumpOcFlag)
        |-> !pumpGateOutput) else $error("pump gate on with overcurrent");
    chk_pump_ot_gate: assert property (pumpOtFlag && $past(pumpOtFlag)
        |-> !pumpGateOutput) else $error("pump gate on with overtemp");
    // Main scenarios reached
    cover property ($rose(overCurrentFlag[0]));
    cover property ($rose(regulationErrorFlag[0]));
    cover property ($rose(pumpOcFlag));
endmodule

/* host_model.sv */
// Purpose: Host side of the supervisor: strobes, clears and pump drive
// Assumes: Strobes last one cycle and change at the falling edge
// Notes: Recovery order is fixed here so tests cannot get it wrong
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire core_clk,
    // Strobes and pump drive
    output logic [3:0] targetWrite,
    output logic [9:0] targetValue,
    output logic [3:0] channelFaultClear,
    output logic [3:0] regErrRead,
    output logic pumpFaultClear,
    output logic pumpDriveInput
);
    // ==========================================
    // Idle state; drive held low, pump_restart drops it low for one cycle only
    initial begin
        {targetWrite, targetValue, channelFaultClear, regErrRead} = 0;
        pumpFaultClear = 0;
        pumpDriveInput = 0;
    end
    // Kind 0 target, 1 clear, 2 error read, 3 pump clear
    task automatic pulse(input int kind, input int ch, input logic [9:0] v);
        @(negedge core_clk);
        targetValue = v;
        case (kind)
            0: targetWrite[ch] = 1;
            1: channelFaultClear[ch] = 1;
            2: regErrRead[ch] = 1;
            default: pumpFaultClear = 1;
        endcase
        @(negedge core_clk);
        {targetWrite, channelFaultClear, regErrRead, pumpFaultClear} = 0;
    endtask
    task automatic recover(input int ch, input logic [9:0] v);
        pulse(1, ch, 10'h000);
        pulse(0, ch, v);
    endtask
    task automatic drive(input logic on);
        @(negedge core_clk);
        pumpDriveInput = on;
    endtask
    // Clear must come before the drive edge
    task automatic pump_restart;
        pulse(3, 0, 10'h000);
        drive(1'b0);
        drive(1'b1);
    endtask
endmodule

/* driver_fault_supervisor_tb.sv */
// Purpose: Directed tests for the driver fault supervisor
// Assumes: Waits of 120 cycles cover sync stages plus the 100-cycle filter
// Notes: Comparator levels come from one vector to keep stimulus short
`timescale 1ns/1ps
module driver_fault_supervisor_tb;
    logic core_clk = 0;
    logic sys_rst = 1;
    logic [17:0] cond = 0;
    logic [3:0] regulationMode = 0;
    logic [39:0] adcCurrent = 0;
    int failCount = 0;
    int checked = 0;
    wire [3:0] openLoadBelow = cond[3:0];
    wire [3:0] drainAboveRef = cond[7:4];
    wire [3:0] chanOverCurrent = cond[11:8];
    wire [3:0] chanOverTemp = cond[15:12];
    wire pumpOverCurrent = cond[16];
    wire pumpOverTemp = cond[17];
    wire [3:0] targetWrite, channelFaultClear, regErrRead, channelOn, openLoadFlag;
    wire [3:0] drainLevelFlag, overCurrentFlag, overTempFlag, regulationErrorFlag;
    wire [9:0] targetValue;
    wire [39:0] targetCode;
    wire pumpDriveInput, pumpFaultClear, pumpGateOutput, pumpOcFlag, pumpOtFlag;
    // ==========================================
    // Clock, host and design
    always #5 core_clk = ~core_clk;
    host_model i_host_model (.core_clk, .targetWrite, .targetValue, .channelFaultClear,
        .regErrRead, .pumpFaultClear, .pumpDriveInput);
    driver_fault_supervisor i_driver_fault_supervisor (.core_clk, .sys_rst, .openLoadBelow,
        .drainAboveRef, .chanOverCurrent, .chanOverTemp, .targetWrite, .targetValue,
        .channelFaultClear, .regErrRead, .regulationMode, .adcCurrent, .pumpDriveInput,
        .pumpOverCurrent, .pumpOverTemp, .pumpFaultClear, .channelOn, .targetCode,
        .openLoadFlag, .drainLevelFlag, .overCurrentFlag, .overTempFlag,
        .regulationErrorFlag, .pumpGateOutput, .pumpOcFlag, .pumpOtFlag);
    // ==========================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (failCount == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Budget is several times the expected 1400 cycles
    initial begin
        #200000;
        failCount++;
        close_out;
    end
    // ==========================================
    // Test sequence
    initial begin
        cyc(12);
        sys_rst = 0;
        chk({channelOn, overCurrentFlag, overTempFlag, pumpGateOutput}, 0);
        i_host_model.pulse(0, 0, 10'h155);
        chk({channelOn, targetCode[9:0]}, {4'h1, 10'h155});
        // A short burst must not qualify
        cond[8] = 1;
        cyc(60);
        cond[8] = 0;
        cyc(60);
        chk(overCurrentFlag, 0);
        cond[8] = 1;
        cyc(120);
        cond[8] = 0;
        chk({overCurrentFlag, channelOn}, 8'h10);
        i_host_model.pulse(0, 0, 10'h155);
        chk(channelOn, 0);
        i_host_model.recover(0, 10'h155);
        chk({overCurrentFlag, channelOn}, 8'h01);
        // Overtemperature on channel 1, clear refused while hot
        i_host_model.pulse(0, 1, 10'h0aa);
        cond[13] = 1;
        cyc(120);
        chk({overTempFlag, channelOn, targetCode[19:10]}, {4'h2, 4'h1, 10'h000});
        i_host_model.pulse(1, 1, 10'h000);
        chk(overTempFlag, 4'h2);
        cond[13] = 0;
        cyc(5);
        i_host_model.recover(1, 10'h0aa);
        chk({overTempFlag, channelOn}, 8'h03);
        // Open load on channel 2, on then off
        i_host_model.pulse(0, 2, 10'h001);
        cond[2] = 1;
        cyc(120);
        chk(openLoadFlag, 0);
        i_host_model.pulse(0, 2, 10'h000);
        cyc(120);
        chk({openLoadFlag, channelOn}, 8'h43);
        cond[2] = 0;
        // Drain level on channel 3 follows the filtered state
        cond[7] = 1;
        cyc(60);
        chk(drainLevelFlag, 0);
        cyc(60);
        chk(drainLevelFlag, 4'h8);
        cond[7] = 0;
        cyc(10);
        chk(drainLevelFlag, 0);
        // Regulation error: outside mode, 24 below, 25 below
        adcCurrent[9:0] = 10'h055;
        cyc(5);
        chk(regulationErrorFlag, 0);
        regulationMode[0] = 1;
        adcCurrent[9:0] = 10'h13d;
        cyc(5);
        chk(regulationErrorFlag, 0);
        adcCurrent[9:0] = 10'h13c;
        cyc(5);
        adcCurrent[9:0] = 10'h155;
        cyc(5);
        chk(regulationErrorFlag, 4'h1);
        i_host_model.pulse(2, 0, 10'h000);
        chk(regulationErrorFlag, 0);
        // Pump: masked start, held count across drive low
        i_host_model.drive(1'b1);
        cyc(10);
        chk(pumpGateOutput, 1);
        cond[16] = 1;
        cyc(120);
        chk({pumpOcFlag, pumpGateOutput}, 2'b01);
        i_host_model.drive(1'b0);
        cyc(20);
        i_host_model.drive(1'b1);
        cyc(120);
        chk({pumpOcFlag, pumpGateOutput}, 2'b10);
        cond[16] = 0;
        i_host_model.pump_restart;
        cyc(10);
        chk({pumpOcFlag, pumpGateOutput}, 2'b01);
        // A gap in overcurrent restarts the count
        cond[16] = 1;
        cyc(100);
        cond[16] = 0;
        cyc(10);
        cond[16] = 1;
        cyc(80);
        cond[16] = 0;
        chk(pumpOcFlag, 0);
        cond[17] = 1;
        cyc(120);
        chk({pumpOtFlag, pumpGateOutput}, 2'b10);
        cond[17] = 0;
        cyc(5);
        i_host_model.pump_restart;
        cyc(10);
        chk({pumpOtFlag, pumpGateOutput}, 2'b01);
        close_out;
    end
endmodule

bind driver_fault_supervisor supervisor_props i_supervisor_props (.core_clk, .sys_rst,
    .chanOverCurrent, .chanOverTemp, .targetWrite, .targetValue, .channelFaultClear,
    .regErrRead, .channelOn, .targetCode, .openLoadFlag, .overCurrentFlag, .overTempFlag,
    .regulationErrorFlag, .pumpGateOutput, .pumpOcFlag, .pumpOtFlag);
